/* rtl/pan_defs.svh */
// Constants for the PHY auto-negotiation and speed configuration block.
// Assumes inclusion by bare name from the rtl/ sources; definitions only.
// Function
// - Negotiation waits for control bit 12; when enabled it starts at once.
// - While negotiating, until the exchange completes, advertisement register abilities go out in pulse bursts.
// - On success, partner abilities are captured into the partner register.
// - Resolved mode: best common of 100F, 100H, 10F, 10H.
// - Negotiation off: bit 13 picks 100 or 10, bit 8 duplex.
// - Negotiation on: speed and duplex control bits are ignored.
// - Status bits 15..11, 3 and 0 are fixed, reporting full ability.
// - Status shows complete in bit 5, remote fault bit 4, link bit 2.
// - Advertisement defaults to all abilities; writes or pins may remove some.
// - Strap pins latch into advertisement and set control register default.
// - Management data pin is undriven while internal reset is asserted.
// - Internal reset is the reset input sampled by the crystal clock.
// - An open-drain interrupt output signals events to the manager.
`ifndef PAN_DEFS_SVH
`define PAN_DEFS_SVH

`define PAN_REG_CTRL 5'h00
`define PAN_REG_STAT 5'h01
`define PAN_REG_ADV 5'h04
`define PAN_REG_LPA 5'h05

`define PAN_CTRL_RESET 15
`define PAN_CTRL_SPEED 13
`define PAN_CTRL_ANEN 12
`define PAN_CTRL_RESTART 9
`define PAN_CTRL_DUPLEX 8

`define PAN_STAT_FIXED 16'hf809
`define PAN_STAT_ANDONE 5
`define PAN_STAT_RFAULT 4
`define PAN_STAT_LINK 2

`define PAN_ADV_SEL 16'h0001
`define PAN_ADV_10H 5
`define PAN_ADV_10F 6
`define PAN_ADV_100H 7
`define PAN_ADV_100F 8
`define PAN_ADV_RF 13

`define PAN_MDIO_ST 2'b01
`define PAN_MDIO_RD 2'b10
`define PAN_MDIO_WR 2'b01
`define PAN_PHY_ADDR 5'h00

// Burst spacing 16 ms nominal; cycles at 100 MHz
`define PAN_BURST_MS 16
`define PAN_BURST_CYC (`PAN_BURST_MS * 100000)
`define PAN_BURSTS_DONE 3
`define PAN_RST_SYNC 2

`endif

/* rtl/pan_pkg.sv */
// Types for the PHY auto-negotiation block.
// Assumes pan_defs.svh supplies the constants.
package pan_pkg;
    typedef enum logic [2:0] {
        PAN_IDLE = 3'b000,
        PAN_SEND = 3'b001,
        PAN_ACK = 3'b010,
        PAN_DONE = 3'b011,
        PAN_FORCED = 3'b100
    } pan_an_state_t;

    typedef enum logic [2:0] {
        PAN_M_PRE = 3'b000,
        PAN_M_HDR = 3'b001,
        PAN_M_TA = 3'b010,
        PAN_M_RDAT = 3'b011,
        PAN_M_WDAT = 3'b100
    } pan_mdio_state_t;

    typedef enum logic [1:0] {
        PAN_MODE_10H = 2'b00,
        PAN_MODE_10F = 2'b01,
        PAN_MODE_100H = 2'b10,
        PAN_MODE_100F = 2'b11
    } pan_mode_t;
endpackage

/* rtl/pan_rst_sync.sv */
// Internal reset generator: reset input sampled by the crystal clock.
// Assumes reset_rc_input is a slow RC level, high meaning run.
`timescale 1ns/100ps
`include "pan_defs.svh"
module pan_rst_sync #(
    parameter int STAGES = `PAN_RST_SYNC
) (
    input wire logic mclk, // Crystal clock
    input wire logic rst, // Asynchronous reset
    input wire logic reset_rc_input, // RC pin, high to run
    output logic power_on_reset_n // Internal reset, active low
);
    typedef struct packed {
        logic [STAGES-1:0] sh;
    } pan_rs_t;
    pan_rs_t r;
    pan_rs_t next_r;

    initial begin
        if (STAGES < 2) begin
            $error("STAGES must be at least 2");
        end
    end

    // Shift the RC level through a plain chain; first stage read only by next
    always_comb begin
        next_r = r;
        next_r.sh = {r.sh[STAGES-2:0], reset_rc_input};
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign power_on_reset_n = r.sh[STAGES-1];
endmodule

/* rtl/pan_flp.sv */
// Pulse burst exchange: sends the advertised word, receives partner word.
// Assumes partner word arrives already decoded as a valid strobe.
`timescale 1ns/100ps
`include "pan_defs.svh"
module pan_flp #(
    parameter int BURST_CYC = `PAN_BURST_CYC,
    parameter int DONE_CNT = `PAN_BURSTS_DONE
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Asynchronous reset
    input wire logic run, // Negotiation running
    input wire logic [15:0] adv_word, // Word to advertise
    input wire logic rx_valid, // Partner word strobe
    input wire logic [15:0] rx_word, // Partner word
    output logic tx_burst, // Burst send pulse
    output logic [15:0] tx_word, // Burst word
    output logic done, // Exchange complete pulse
    output logic [15:0] lp_word // Last received partner word
);
    typedef struct packed {
        logic [31:0] tmr;
        logic [3:0] match;
        logic [15:0] last;
        logic burst;
        logic [15:0] word;
        logic done;
    } pan_flp_t;
    pan_flp_t r;
    pan_flp_t next_r;

    initial begin
        if (BURST_CYC < 1 || DONE_CNT < 1 || DONE_CNT > 15) begin
            $error("bad burst parameters");
        end
    end

    // Bursts repeat while running; identical partner words count toward done
    always_comb begin
        next_r = r;
        next_r.burst = 1'b0;
        next_r.done = 1'b0;
        if (!run) begin
            next_r.tmr = '0;
            next_r.match = '0;
        end else begin
            if (r.tmr == 32'h0) begin
                next_r.burst = 1'b1;
                next_r.word = adv_word;
                next_r.tmr = 32'(BURST_CYC - 1);
            end else begin
                next_r.tmr = r.tmr - 32'h1;
            end
            if (rx_valid) begin
                next_r.last = rx_word;
                if (rx_word == r.last && r.match != 4'(DONE_CNT)) begin
                    next_r.match = r.match + 4'h1;
                end else if (rx_word != r.last) begin
                    next_r.match = 4'h1;
                end
                if (rx_word == r.last && r.match == 4'(DONE_CNT - 1)) begin
                    next_r.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tx_burst = r.burst;
    assign tx_word = r.word;
    assign done = r.done;
    assign lp_word = r.last;
endmodule

/* rtl/pan_top.sv */
// Auto-negotiation, speed and duplex control with its management registers.
// Assumes mdc is synchronous to mclk and sampled on its rising edges;
// strap pins are stable while the RC reset is low.
`timescale 1ns/100ps
`include "pan_defs.svh"
module pan_top #(
    parameter int BURST_CYC = `PAN_BURST_CYC // Burst spacing in cycles
) (
    input wire logic mclk, // 100 MHz clock
    input wire logic rst, // Asynchronous reset
    input wire logic reset_rc_input, // RC power-on pin
    input wire logic serial_mgmt_clock, // Management clock
    input wire logic mdio_in, // Management data in
    output logic mdio_out, // Management data out
    output logic mdio_oe, // Management data drive enable
    input wire logic [3:0] strap_adv, // 100F,100H,10F,10H strap
    input wire logic strap_an_en, // Strap: negotiation enable
    input wire logic link_ok, // Line has valid signal
    input wire logic lp_valid, // Partner word strobe
    input wire logic [15:0] lp_word, // Partner word
    output logic flp_send, // Send burst pulse
    output logic [15:0] flp_word, // Burst word
    output logic speed_100, // Operating at 100 Mbps
    output logic full_duplex, // Operating full duplex
    output logic int_oe // Interrupt pin pulls low
);
    typedef struct packed {
        pan_pkg::pan_an_state_t an;
        pan_pkg::pan_mdio_state_t ms;
        logic [15:0] ctrl;
        logic [15:0] adv;
        logic [15:0] lpa;
        logic an_done;
        logic link;
        logic strapped;
        logic mdc_d;
        logic [5:0] cnt;
        logic [13:0] hdr;
        logic [15:0] sh;
        logic mdo;
        logic moe;
        logic spd;
        logic dup;
        logic irq;
        logic int_o;
    } pan_st_t;
    pan_st_t r;
    pan_st_t next_r;

    logic por_n;
    logic flp_run;
    logic flp_done;
    logic [15:0] flp_lp;
    logic [1:0] mode;

    // Read mux shared by the serial engine
    function automatic logic [15:0] rd_reg(input logic [4:0] a,
                                           input pan_st_t s);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            `PAN_REG_CTRL: v = s.ctrl;
            `PAN_REG_STAT: begin
                v = `PAN_STAT_FIXED;
                v[`PAN_STAT_ANDONE] = s.an_done;
                v[`PAN_STAT_RFAULT] = s.lpa[`PAN_ADV_RF];
                v[`PAN_STAT_LINK] = s.link;
            end
            `PAN_REG_ADV: v = s.adv;
            `PAN_REG_LPA: v = s.lpa;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Priority resolve of common abilities
    function automatic logic [1:0] resolve(input logic [15:0] a,
                                           input logic [15:0] b);
        logic [15:0] c;
        c = a & b;
        if (c[`PAN_ADV_100F]) begin
            return pan_pkg::PAN_MODE_100F;
        end else if (c[`PAN_ADV_100H]) begin
            return pan_pkg::PAN_MODE_100H;
        end else if (c[`PAN_ADV_10F]) begin
            return pan_pkg::PAN_MODE_10F;
        end else begin
            return pan_pkg::PAN_MODE_10H;
        end
    endfunction

    pan_rst_sync u_rst (
        .mclk(mclk),
        .rst(rst),
        .reset_rc_input(reset_rc_input),
        .power_on_reset_n(por_n)
    );

    assign flp_run = (r.an == pan_pkg::PAN_SEND) && por_n;

    pan_flp #(
        .BURST_CYC(BURST_CYC),
        .DONE_CNT(`PAN_BURSTS_DONE)
    ) u_flp (
        .mclk(mclk),
        .rst(rst),
        .run(flp_run),
        .adv_word(r.adv),
        .rx_valid(lp_valid),
        .rx_word(lp_word),
        .tx_burst(flp_send),
        .tx_word(flp_word),
        .done(flp_done),
        .lp_word(flp_lp)
    );

    assign mode = resolve(r.adv, r.lpa);

    // Next state: straps, negotiation, serial management, mode outputs
    always_comb begin
        logic rise;
        logic [15:0] wd;
        logic restart;
        rise = 1'b0;
        wd = 16'h0000;
        restart = 1'b0;
        next_r = r;
        next_r.mdc_d = serial_mgmt_clock;
        rise = serial_mgmt_clock && !r.mdc_d;
        next_r.link = link_ok;
        next_r.irq = 1'b0;
        if (!por_n) begin
            // Latch straps while held in reset
            next_r.adv = `PAN_ADV_SEL;
            next_r.adv[`PAN_ADV_100F:`PAN_ADV_10H] = strap_adv;
            next_r.ctrl = 16'h0000;
            next_r.ctrl[`PAN_CTRL_ANEN] = strap_an_en;
            next_r.ctrl[`PAN_CTRL_SPEED] = strap_adv[3] | strap_adv[2];
            next_r.ctrl[`PAN_CTRL_DUPLEX] = strap_adv[3] | strap_adv[1];
            next_r.strapped = 1'b1;
            next_r.an = pan_pkg::PAN_IDLE;
            next_r.ms = pan_pkg::PAN_M_PRE;
            next_r.cnt = 6'h00;
            next_r.moe = 1'b0;
            next_r.an_done = 1'b0;
            next_r.lpa = 16'h0000;
        end else begin
            // Serial management frame engine, stepped on clock rises
            if (rise) begin
                case (r.ms)
                    pan_pkg::PAN_M_PRE: begin
                        next_r.moe = 1'b0;
                        if (mdio_in) begin
                            next_r.cnt = (r.cnt == 6'h3f) ? r.cnt
                                                           : r.cnt + 6'h01;
                        end else if (r.cnt >= 6'h1f) begin
                            next_r.ms = pan_pkg::PAN_M_HDR;
                            next_r.hdr = 14'h0000;
                            next_r.cnt = 6'h01;
                        end else begin
                            next_r.cnt = 6'h00;
                        end
                    end
                    pan_pkg::PAN_M_HDR: begin
                        next_r.hdr = {r.hdr[12:0], mdio_in};
                        next_r.cnt = r.cnt + 6'h01;
                        if (r.cnt == 6'h0d) begin
                            next_r.ms = pan_pkg::PAN_M_TA;
                            next_r.cnt = 6'h00;
                        end
                    end
                    pan_pkg::PAN_M_TA: begin
                        next_r.cnt = r.cnt + 6'h01;
                        // Header holds start bit, op, phy, reg in [12:0]
                        if (r.hdr[11:10] == `PAN_MDIO_RD &&
                            r.hdr[9:5] == `PAN_PHY_ADDR) begin
                            if (r.cnt == 6'h00) begin
                                next_r.moe = 1'b1;
                                next_r.mdo = 1'b0;
                                next_r.sh = rd_reg(r.hdr[4:0], r);
                                next_r.ms = pan_pkg::PAN_M_RDAT;
                                next_r.cnt = 6'h00;
                            end
                        end else if (r.cnt == 6'h00) begin
                            next_r.ms = pan_pkg::PAN_M_WDAT;
                            next_r.cnt = 6'h00;
                        end
                    end
                    pan_pkg::PAN_M_RDAT: begin
                        next_r.mdo = r.sh[15];
                        next_r.sh = {r.sh[14:0], 1'b0};
                        next_r.cnt = r.cnt + 6'h01;
                        if (r.cnt == 6'h10) begin
                            next_r.moe = 1'b0;
                            next_r.ms = pan_pkg::PAN_M_PRE;
                            next_r.cnt = 6'h00;
                        end
                    end
                    pan_pkg::PAN_M_WDAT: begin
                        next_r.sh = {r.sh[14:0], mdio_in};
                        next_r.cnt = r.cnt + 6'h01;
                        if (r.cnt == 6'h10) begin
                            next_r.ms = pan_pkg::PAN_M_PRE;
                            next_r.cnt = 6'h00;
                            // Last data bit is still on the line
                            wd = {r.sh[14:0], mdio_in};
                            if (r.hdr[11:10] == `PAN_MDIO_WR &&
                                r.hdr[9:5] == `PAN_PHY_ADDR) begin
                                if (r.hdr[4:0] == `PAN_REG_CTRL) begin
                                    next_r.ctrl = wd;
                                    next_r.ctrl[`PAN_CTRL_RESET] = 1'b0;
                                    restart = wd[`PAN_CTRL_RESTART];
                                end else if (r.hdr[4:0] == `PAN_REG_ADV) begin
                                    // Selector field stays fixed
                                    next_r.adv = wd;
                                    next_r.adv[4:0] = 5'h01;
                                end
                            end
                        end
                    end
                    default: next_r.ms = pan_pkg::PAN_M_PRE;
                endcase
            end
            // Negotiation sequence
            case (r.an)
                pan_pkg::PAN_IDLE: begin
                    if (r.ctrl[`PAN_CTRL_ANEN]) begin
                        next_r.an = pan_pkg::PAN_SEND;
                    end else begin
                        next_r.an = pan_pkg::PAN_FORCED;
                    end
                end
                pan_pkg::PAN_SEND: begin
                    if (flp_done) begin
                        next_r.lpa = flp_lp;
                        next_r.an = pan_pkg::PAN_DONE;
                        next_r.an_done = 1'b1;
                        next_r.irq = 1'b1;
                    end
                end
                pan_pkg::PAN_DONE: begin
                    next_r.spd = mode[1];
                    next_r.dup = mode[0];
                end
                pan_pkg::PAN_FORCED: begin
                    next_r.spd = r.ctrl[`PAN_CTRL_SPEED];
                    next_r.dup = r.ctrl[`PAN_CTRL_DUPLEX];
                    if (r.ctrl[`PAN_CTRL_ANEN]) begin
                        next_r.an = pan_pkg::PAN_SEND;
                    end
                end
                default: next_r.an = pan_pkg::PAN_IDLE;
            endcase
            if (restart || (r.an == pan_pkg::PAN_DONE &&
                            !next_r.ctrl[`PAN_CTRL_ANEN])) begin
                // Restart or disable drops the old result
                next_r.an = pan_pkg::PAN_IDLE;
                next_r.an_done = 1'b0;
                next_r.lpa = 16'h0000;
                next_r.ctrl[`PAN_CTRL_RESTART] = 1'b0;
            end
            if (r.link && !link_ok) begin
                next_r.irq = 1'b1;
            end
        end
        // Interrupt held until any frame to the status register reaches turnaround; set wins, dropped in reset
        next_r.int_o = por_n && (next_r.irq || (r.int_o && !(rise &&
                       r.ms == pan_pkg::PAN_M_TA &&
                       r.hdr[4:0] == `PAN_REG_STAT)));
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign mdio_out = r.mdo;
    assign mdio_oe = r.moe;
    assign speed_100 = r.spd;
    assign full_duplex = r.dup;
    assign int_oe = r.int_o;
endmodule

/* tb/pan_top_props.sv */
// Port-level checker for the auto-negotiation block, bound to pan_top.
// Assumes the bench keeps the advertisement selector field at 5'h01.
`timescale 1ns/100ps
module pan_top_props (
    input wire logic mclk, // System clock
    input wire logic rst, // Asynchronous reset
    input wire logic reset_rc_input, // RC power-on pin
    input wire logic link_ok, // Line has valid signal
    input wire logic mdio_oe, // Management data drive enable
    input wire logic flp_send, // Burst pulse
    input wire logic [15:0] flp_word, // Burst word
    input wire logic int_oe // Interrupt pull enable
);
    // No disable here: the reset itself is the cause
    a_rst_quiet: assert property (
        @(posedge mclk) rst |-> !mdio_oe && !flp_send && !int_oe)
        else $error("Outputs active during reset");
    // Five low samples leave room for the two sync flops
    a_mdio_float: assert property (
        @(posedge mclk) disable iff (rst)
        (!reset_rc_input) [*5] |-> !mdio_oe)
        else $error("Data pin driven in internal reset");
    a_burst_held: assert property (
        @(posedge mclk) disable iff (rst)
        (!reset_rc_input) [*5] |-> !flp_send)
        else $error("Burst sent in internal reset");
    a_int_held: assert property (
        @(posedge mclk) disable iff (rst)
        (!reset_rc_input) [*5] |-> !int_oe)
        else $error("Interrupt in internal reset");
    a_burst_pulse: assert property (
        @(posedge mclk) disable iff (rst)
        flp_send |=> !flp_send)
        else $error("Burst pulse longer than one cycle");
    a_burst_sel: assert property (
        @(posedge mclk) disable iff (rst)
        flp_send |-> flp_word[4:0] == 5'h01)
        else $error("Burst word selector wrong");
    a_link_int: assert property (
        @(posedge mclk) disable iff (rst)
        $fell(link_ok) && reset_rc_input |-> ##[1:6] int_oe)
        else $error("No interrupt on link loss");
    a_int_hold: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(int_oe) |=> int_oe [*8])
        else $error("Interrupt dropped without status read");
endmodule

bind pan_top pan_top_props u_props (.mclk, .rst, .reset_rc_input,
    .link_ok, .mdio_oe, .flp_send, .flp_word, .int_oe);

/* tb/pan_link_partner.sv */
// Behavioural remote link partner: answers each burst with its word.
// Assumes the block pulses flp_send once per burst.
`timescale 1ns/100ps
module pan_link_partner (
    input wire logic mclk, // System clock
    input wire logic flp_send, // Burst pulse from the block
    input wire logic [15:0] ability, // Word this partner advertises
    input wire logic slow, // Answer late instead of promptly
    output logic lp_valid, // Partner word strobe
    output logic [15:0] lp_word // Partner word
);
    int wait_cnt = -1;

    initial begin
        lp_valid = 1'b0;
        lp_word = 16'h0000;
    end
    // Word toggles outside strobes so no stale value can be trusted
    always @(posedge mclk) begin
        lp_valid <= 1'b0;
        lp_word <= ~lp_word;
        if (flp_send === 1'b1) begin
            wait_cnt <= slow ? 20 : 1;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (wait_cnt == 0) begin
            lp_valid <= 1'b1;
            lp_word <= ability;
            wait_cnt <= -1;
        end
    end
endmodule

/* tb/pan_top_tb_top.sv */
// Self-checking bench for pan_top: management frames, negotiation, modes.
// Assumes a short burst spacing and a management clock of 8 system cycles.
`timescale 1ns/100ps
`include "pan_defs.svh"
module pan_top_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b0;
    logic [3:0] strap = 4'hf;
    logic strap_en = 1'b1;
    logic reset_rc_input = 1'b0;
    logic serial_mgmt_clock = 1'b0;
    logic host_bit = 1'b1;
    logic link_ok = 1'b1;
    logic slow = 1'b0;
    logic [15:0] ability = 16'h01e1;
    logic [15:0] adv_m = 16'h01e1;
    logic mdio_out, mdio_oe, lp_valid, flp_send, speed_100, full_duplex;
    logic int_oe;
    logic [15:0] lp_word, flp_word, q, adv, pw;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_burst = 0;
    int seed = 32'hdc26d6e8;
    int n0;
    // Released pin floats high through its pull-up
    wire mdio_in = mdio_oe ? mdio_out : host_bit;
    wire [1:0] mode = {speed_100, full_duplex};

    pan_top #(.BURST_CYC(50)) u_dut (.mclk, .rst, .reset_rc_input,
        .serial_mgmt_clock, .mdio_in, .mdio_out, .mdio_oe,
        .strap_adv(strap), .strap_an_en(strap_en), .link_ok, .lp_valid,
        .lp_word, .flp_send, .flp_word, .speed_100, .full_duplex, .int_oe);
    pan_link_partner u_partner (.mclk, .flp_send, .ability, .slow,
        .lp_valid, .lp_word);

    always #5 mclk = ~mclk;

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    // One management bit; line sampled just before the clock rises
    task automatic mbit(input logic b, output logic r);
        host_bit = b;
        cyc(4);
        r = mdio_in;
        serial_mgmt_clock = 1'b1;
        cyc(4);
        serial_mgmt_clock = 1'b0;
    endtask
    task automatic frame(input logic rd_op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] hdr;
        logic r;
        hdr = {2'b01, rd_op ? 2'b10 : 2'b01, phy, ra,
               rd_op ? 2'b11 : 2'b10};
        for (int i = 0; i < 32; i++) mbit(1'b1, r);
        for (int i = 15; i >= 0; i--) mbit(hdr[i], r);
        for (int i = 15; i >= 0; i--) begin
            mbit(rd_op ? 1'b1 : wd[i], r);
            q[i] = r;
        end
        host_bit = 1'b1;
    endtask
    task automatic wait_int;
        for (int k = 0; k < 3000 && int_oe !== 1'b1; k++) cyc(1);
        chk("int_oe", 16'h0001, {15'h0, int_oe});
    endtask
    function automatic logic [15:0] stat(input logic rf, input logic lk);
        return `PAN_STAT_FIXED | 16'h0020 | {11'h0, rf, 1'b0, lk, 2'b00};
    endfunction
    // Best common ability, coded as speed then duplex
    function automatic logic [15:0] best(input logic [15:0] a,
                                         input logic [15:0] p);
        for (int b = 8; b >= 5; b--) if (a[b] && p[b]) return 16'(b - 5);
        return 16'h0000;
    endfunction
    task automatic complete_run;
        if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Every burst must carry the advertised word; settled mid-cycle
    always @(negedge mclk) begin
        if (flp_send === 1'b1) begin
            n_burst++;
            chk("burst word", adv_m, flp_word);
        end
    end

    initial begin
        repeat (80000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        #1 rst = 1'b1;
        cyc(16);
        rst = 1'b0;
        cyc(40);
        reset_rc_input = 1'b1;
        wait_int();
        frame(1'b1, 5'h00, 5'h00, 16'h0); chk("ctrl", 16'h3100, q);
        frame(1'b1, 5'h00, 5'h04, 16'h0); chk("adv", 16'h01e1, q);
        frame(1'b1, 5'h00, 5'h01, 16'h0); chk("status", stat(0, 1), q);
        chk("int clear", 16'h0000, {15'h0, int_oe});
        frame(1'b1, 5'h00, 5'h02, 16'h0); chk("unmapped", 16'h0000, q);
        frame(1'b1, 5'h01, 5'h01, 16'h0); chk("phy addr", 16'hffff, q);
        frame(1'b0, 5'h00, 5'h01, 16'h0000);
        frame(1'b1, 5'h00, 5'h01, 16'h0); chk("status ro", stat(0, 1), q);
        // Every single mode first, then random overlaps
        for (int i = 0; i < 7; i++) begin
            adv = 16'h01e1;
            pw = 16'h0001 | (16'h0020 << i);
            if (i >= 4) begin
                adv = 16'h0021 | (16'($random(seed)) & 16'h01e0);
                pw = 16'h0021 | (16'($random(seed)) & 16'h21e0);
            end
            if (i == 1) pw = pw | 16'h2000;
            ability = pw;
            slow = i[0];
            adv_m = adv;
            frame(1'b0, 5'h00, 5'h04, adv);
            frame(1'b0, 5'h00, 5'h00, 16'h1200);
            wait_int();
            frame(1'b1, 5'h00, 5'h01, 16'h0);
            chk("status", stat(pw[13], 1'b1), q);
            frame(1'b1, 5'h00, 5'h05, 16'h0); chk("partner", pw, q);
            chk("mode", best(adv, pw), {14'h0, mode});
            frame(1'b1, 5'h00, 5'h00, 16'h0); chk("restart", 16'h1000, q);
        end
        // Forced modes: no bursts, control bits rule
        for (int m = 0; m < 4; m++) begin
            n0 = n_burst;
            frame(1'b0, 5'h00, 5'h00, {2'b00, m[1], 4'h0, m[0], 8'h00});
            cyc(20);
            chk("forced", 16'(m), {14'h0, mode});
            chk("no burst", 16'(n0), 16'(n_burst));
        end
        frame(1'b1, 5'h00, 5'h01, 16'h0);
        frame(1'b0, 5'h00, 5'h00, 16'h1000);
        wait_int();
        // Mode follows the done state one cycle later
        cyc(2);
        chk("enable mode", best(adv, pw), {14'h0, mode});
        frame(1'b1, 5'h00, 5'h01, 16'h0);
        link_ok = 1'b0;
        wait_int();
        frame(1'b1, 5'h00, 5'h01, 16'h0);
        chk("link bit", 16'h0000, {15'h0, q[2]});
        link_ok = 1'b1;
        // Second internal reset with other straps: forced 100 half
        n0 = n_burst;
        strap = 4'h4;
        strap_en = 1'b0;
        reset_rc_input = 1'b0;
        cyc(8);
        reset_rc_input = 1'b1;
        cyc(4);
        frame(1'b1, 5'h00, 5'h00, 16'h0);
        chk("strap ctrl", 16'h2000, q);
        frame(1'b1, 5'h00, 5'h04, 16'h0);
        chk("strap adv", 16'h0081, q);
        chk("strap mode", 16'h0002, {14'h0, mode});
        chk("strap burst", 16'(n0), 16'(n_burst));
        cyc(10);
        complete_run();
    end
endmodule
